// *** hw/ict_consts.svh ***
// cycle figures and widths for the instruction cycle timing block
`ifndef ICT_CONSTS_SVH
`define ICT_CONSTS_SVH

// ==========================================================================
// cycle counts, zero wait states
`define ICT_CYC_ALU          5'h01
`define ICT_CYC_PC_WRITE     5'h02
`define ICT_CYC_MEM_BUS      5'h02
`define ICT_CYC_MEM_IO       5'h01
`define ICT_CYC_MULTI_BASE   5'h01
`define ICT_CYC_POP_PC_BASE  5'h03
`define ICT_CYC_BR_TAKEN     5'h02
`define ICT_CYC_BR_NOT       5'h01
`define ICT_CYC_BR_UNCOND    5'h02
`define ICT_CYC_CALL         5'h03
`define ICT_CYC_BR_REG       5'h02
`define ICT_CYC_HINT         5'h01
`define ICT_CYC_SLEEP_HINT   5'h02
`define ICT_CYC_SYSREG       5'h03
`define ICT_CYC_BARRIER      5'h03
`define ICT_CYC_TRAP         5'h01

// ==========================================================================
// widths
`define ICT_CYC_W            5
`define ICT_ELAPSED_W        8

`endif

// *** hw/ict_pkg.sv ***
// types shared by the instruction cycle timing block
package ict_pkg;

   // ==========================================================================
   // instruction timing classes
   typedef enum logic [2:0] {
      ICT_CLS_FIXED  = 3'h0,
      ICT_CLS_MEM    = 3'h1,
      ICT_CLS_MULTI  = 3'h2,
      ICT_CLS_COND   = 3'h3,
      ICT_CLS_SLEEP  = 3'h4,
      ICT_CLS_UNDEF  = 3'h5
   } ict_class_t;

   // ==========================================================================
   // sequencer states
   typedef enum logic [1:0] {
      ICT_ST_IDLE  = 2'h0,
      ICT_ST_EXEC  = 2'h1,
      ICT_ST_SLEEP = 2'h2
   } ict_state_t;

endpackage : ict_pkg

// *** hw/ict_dec_if.sv ***
// decode request and answer between sequencer and classifier
`timescale 1ns/1ps
interface ict_dec_if;
   import ict_pkg::*;
   logic [15:0]  hw1;
   logic [15:0]  hw2;
   ict_class_t   cls;
   logic [4:0]   fixed_cycles;
   logic [4:0]   list_count;

   modport core (output hw1, output hw2, input cls, input fixed_cycles, input list_count);
   modport dec  (input hw1, input hw2, output cls, output fixed_cycles, output list_count);
endinterface : ict_dec_if

// *** hw/ict_classify.sv ***
// combinational instruction classifier: accepted subset and base cycles
`timescale 1ns/1ps
`include "ict_consts.svh"
module ict_classify
   import ict_pkg::*;
(
   ict_dec_if.dec dec_bus
);
   wire [15:0] h = dec_bus.hw1;
   wire [15:0] w = dec_bus.hw2;

   // ==========================================================================
   // 32-bit forms
   wire is_wide   = (h[15:13] == 3'h7) && (h[12:11] != 2'h0);
   wire m_call    = (h[15:11] == 5'h1e) && (w[15:14] == 2'h3) && w[12];
   wire m_barrier = (h == 16'hf3bf) && (w[15:8] == 8'h8f)
                    && (w[7:4] >= 4'h4) && (w[7:4] <= 4'h6);
   wire m_sysrd   = (h == 16'hf3ef) && (w[15:12] == 4'h8);
   wire m_syswr   = (h[15:4] == 12'hf38) && (w[15:12] == 4'h8);
   wire wide_ok   = m_call | m_barrier | m_sysrd | m_syswr;

   // ==========================================================================
   // 16-bit miscellaneous group
   wire m_misc    = (h[15:12] == 4'hb);
   wire m_hint    = (h[15:8] == 8'hbf) && (h[3:0] == 4'h0);
   wire m_sleep   = m_hint && ((h[7:4] == 4'h2) || (h[7:4] == 4'h3));
   wire m_push    = (h[15:9] == 7'h5a);
   wire m_pop     = (h[15:9] == 7'h5e);
   wire m_cps     = (h[15:5] == 11'h5b3);
   wire m_ext     = (h[15:8] == 8'hb2);
   wire m_rev     = (h[15:8] == 8'hba) && (h[7:6] != 2'h2);
   wire m_spadj   = (h[15:8] == 8'hb0);
   wire m_bkpt    = (h[15:8] == 8'hbe);
   // zero-compare branches and the conditional block fall outside this list
   wire misc_ok   = m_push | m_pop | m_cps | m_ext | m_rev | m_spadj | m_hint | m_bkpt;

   // ==========================================================================
   // remaining 16-bit groups
   wire m_udf     = (h[15:8] == 8'hde);
   wire m_svc     = (h[15:8] == 8'hdf);
   wire m_cond    = (h[15:12] == 4'hd) && (h[11:9] != 3'h7);
   wire m_uncond  = (h[15:11] == 5'h1c);
   wire m_multi   = (h[15:12] == 4'hc) | m_push | m_pop;
   wire m_bx      = (h[15:8] == 8'h47);
   wire m_pcwr    = (h[15:10] == 6'h11) && !h[8] && h[7] && (h[2:0] == 3'h7);
   wire m_mem     = (h[15:11] == 5'h09) | (h[15:12] == 4'h5)
                    | (h[15:13] == 3'h3) | (h[15:13] == 3'h4);
   wire m_undef   = is_wide ? !wide_ok : (m_udf | (m_misc && !misc_ok));

   // pc and lr count as list entries alongside the low registers
   wire [4:0] low_count = 5'($countones(h[7:0]));
   assign dec_bus.list_count = low_count
                               + {4'h0, (m_push | m_pop) & h[8]};

   // ==========================================================================
   // base cycle selection; ALU, shift, extend, reverse and multiply default to one
   assign dec_bus.fixed_cycles =
      is_wide                  ? (m_call ? `ICT_CYC_CALL :
                                  m_barrier ? `ICT_CYC_BARRIER :
                                  `ICT_CYC_SYSREG) :
      (m_pop && h[8])          ? `ICT_CYC_POP_PC_BASE :
      m_multi                  ? `ICT_CYC_MULTI_BASE :
      m_bx                     ? `ICT_CYC_BR_REG :
      m_pcwr                   ? `ICT_CYC_PC_WRITE :
      m_uncond                 ? `ICT_CYC_BR_UNCOND :
      m_sleep                  ? `ICT_CYC_SLEEP_HINT :
      (m_bkpt | m_svc)         ? `ICT_CYC_TRAP :
      m_hint                   ? `ICT_CYC_HINT :
      `ICT_CYC_ALU;

   assign dec_bus.cls =
      m_undef  ? ICT_CLS_UNDEF :
      is_wide  ? ICT_CLS_FIXED :
      m_mem    ? ICT_CLS_MEM :
      m_multi  ? ICT_CLS_MULTI :
      m_cond   ? ICT_CLS_COND :
      m_sleep  ? ICT_CLS_SLEEP :
      ICT_CLS_FIXED;

endmodule : ict_classify

// *** hw/ict_timing.sv ***
// instruction cycle timing sequencer: takes one instruction, holds it for its cycle count
`timescale 1ns/1ps
`include "ict_consts.svh"

// What this block does
// - accept all compact 16-bit forms except zero-compare branches, conditional blocks and the permanently undefined (udf) form.
// - accept only call, three barriers and special-register read/write as 32-bit.
// - counts assume zero wait states; bus wait cycles lengthen the instruction.
// - moves, adds, subtracts, compares, logic and multiply take 1; pc writes 2.
// - all shifts and rotate take 1 cycle, immediate or register amount.
// - single loads and stores of any width and addressing take 2 or 1.
// - multiple transfers take 1+N; pop loading pc takes 3+N.
// - conditional branch 1 or 2, unconditional 2, call 3, register branch 2.
// - signed and unsigned byte and halfword extends take 1 cycle.
// - byte-reverse forms each take 1 cycle.
// - single access takes 2 to system bus or control space, 1 to I/O port.
// - list count includes link register or program counter when listed.
// - conditional branch takes 2 when taken, 1 when not taken.
// - event and yield hints 1; sleep hints 2, excluding time suspended.
module ict_timing
   import ict_pkg::*;
(
   input  wire logic                       clk_sys,
   input  wire logic                       reset_n,
   input  wire logic                       instr_valid,
   input  wire logic [15:0]                instr_hw1,
   input  wire logic [15:0]                instr_hw2,
   input  wire logic                       cond_pass,
   input  wire logic                       target_io,
   input  wire logic                       bus_wait,
   input  wire logic                       wake_event,
   output logic                            instr_ready,
   output logic                            retire,
   output logic                            undef_fault,
   output logic                            sleeping,
   output logic [`ICT_ELAPSED_W-1:0]       cycles_used
);

   // ==========================================================================
   // classifier
   ict_dec_if dec_bus ();

   assign dec_bus.hw1 = instr_hw1;
   assign dec_bus.hw2 = instr_hw2;

   ict_classify u_classify (
      .dec_bus (dec_bus.dec)
   );

   // ==========================================================================
   // state
   ict_state_t                state;
   ict_state_t                next_state;
   logic [`ICT_CYC_W-1:0]     remain;
   logic [`ICT_CYC_W-1:0]     next_remain;
   logic [`ICT_ELAPSED_W-1:0] elapsed;
   logic [`ICT_ELAPSED_W-1:0] next_elapsed;
   logic [`ICT_ELAPSED_W-1:0] next_cycles;
   logic                      sleep_cls;
   logic                      next_sleep_cls;
   logic                      next_retire;
   logic                      next_fault;

   // ==========================================================================
   // cycle total for the offered instruction
   wire       take      = instr_valid && instr_ready;
   wire       take_nw   = take && !bus_wait;
   wire [4:0] mem_cyc   = target_io ? `ICT_CYC_MEM_IO : `ICT_CYC_MEM_BUS;
   wire [4:0] cond_cyc  = cond_pass ? `ICT_CYC_BR_TAKEN : `ICT_CYC_BR_NOT;
   wire [4:0] multi_cyc = dec_bus.fixed_cycles + dec_bus.list_count;
   wire [4:0] total     = (dec_bus.cls == ICT_CLS_MEM)   ? mem_cyc :
                          (dec_bus.cls == ICT_CLS_COND)  ? cond_cyc :
                          (dec_bus.cls == ICT_CLS_MULTI) ? multi_cyc :
                          dec_bus.fixed_cycles;
   // a wait on the take cycle means that cycle does not count down
   wire [4:0] first_rem = bus_wait ? total : total - 5'h01;

   // ==========================================================================
   // next-state logic
   always_comb begin
      logic fin;
      fin            = 1'b0;
      next_state     = state;
      next_remain    = remain;
      next_elapsed   = elapsed;
      next_retire    = 1'b0;
      next_fault     = 1'b0;
      next_cycles    = cycles_used;
      next_sleep_cls = sleep_cls;
      unique case (state)
         ICT_ST_IDLE: begin
            if (take && dec_bus.cls == ICT_CLS_UNDEF) begin
               next_fault = 1'b1;
            end else if (take) begin
               next_sleep_cls = (dec_bus.cls == ICT_CLS_SLEEP);
               next_elapsed   = 8'h01;
               next_remain    = first_rem;
               if (first_rem == 5'h00) begin
                  fin = 1'b1;
               end else begin
                  next_state = ICT_ST_EXEC;
               end
            end
         end
         ICT_ST_EXEC: begin
            next_elapsed = elapsed + 8'h01;
            if (!bus_wait) begin
               next_remain = remain - 5'h01;
               fin         = (remain == 5'h01);
            end
         end
         ICT_ST_SLEEP: begin
            // suspended time is never added to the count
            if (wake_event) begin
               next_state  = ICT_ST_IDLE;
               next_retire = 1'b1;
            end
         end
         default: begin
            next_state = ICT_ST_IDLE;
         end
      endcase
      if (fin) begin
         next_cycles = next_elapsed;
         next_state  = next_sleep_cls ? ICT_ST_SLEEP : ICT_ST_IDLE;
         next_retire = !next_sleep_cls;
      end
   end

   // ==========================================================================
   // registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state       <= ICT_ST_IDLE;
         remain      <= 5'h00;
         elapsed     <= 8'h00;
         sleep_cls   <= 1'b0;
         instr_ready <= 1'b1;
         retire      <= 1'b0;
         undef_fault <= 1'b0;
         sleeping    <= 1'b0;
         cycles_used <= 8'h00;
      end else begin
         state       <= next_state;
         remain      <= next_remain;
         elapsed     <= next_elapsed;
         sleep_cls   <= next_sleep_cls;
         instr_ready <= (next_state == ICT_ST_IDLE);
         retire      <= next_retire;
         undef_fault <= next_fault;
         sleeping    <= (next_state == ICT_ST_SLEEP);
         cycles_used <= next_cycles;
      end
   end

   // ==========================================================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   dp_one_cycle_a: assert property (take_nw && instr_hw1[15:10] == 6'h10 |=>
      retire && instr_ready && cycles_used == 8'h01)
      else $error("data processing did not take one cycle");

   shift_one_cycle_a: assert property (take_nw && instr_hw1[15:13] == 3'h0 |=>
      retire && cycles_used == 8'h01)
      else $error("shift did not take one cycle");

   mem_io_a: assert property (take_nw && dec_bus.cls == ICT_CLS_MEM && target_io
      |=> retire && cycles_used == 8'h01)
      else $error("i/o port access did not take one cycle");

   mem_bus_a: assert property ((take_nw && dec_bus.cls == ICT_CLS_MEM && !target_io)
      ##1 !bus_wait |=> retire && cycles_used == 8'h02)
      else $error("system bus access did not take two cycles");

   push_lr_count_a: assert property ((take_nw && instr_hw1 == 16'hb501)
      ##1 (!bus_wait && !retire)[*2] |=> retire && cycles_used == 8'h03)
      else $error("push with link did not take 1+N cycles");

   call_three_a: assert property ((take_nw && instr_hw1[15:11] == 5'h1e
      && instr_hw2[15:14] == 2'h3 && instr_hw2[12]) ##1 (!bus_wait)[*2]
      |=> retire && cycles_used == 8'h03)
      else $error("call did not take three cycles");

   cond_taken_a: assert property ((take_nw && instr_hw1[15:12] == 4'hd
      && instr_hw1[11:9] != 3'h7 && cond_pass) ##1 !bus_wait
      |=> retire && cycles_used == 8'h02)
      else $error("taken branch did not take two cycles");

   cond_not_taken_a: assert property (take_nw && instr_hw1[15:12] == 4'hd
      && instr_hw1[11:9] != 3'h7 && !cond_pass |=> retire && cycles_used == 8'h01)
      else $error("untaken branch did not take one cycle");

   zero_branch_a: assert property (take && instr_hw1[15:12] == 4'hb
      && !instr_hw1[10] && instr_hw1[8] |=> undef_fault && !retire)
      else $error("zero-compare branch was not refused");

   wide_refuse_a: assert property (take && instr_hw1[15:11] == 5'h1d
      |=> undef_fault && !retire && instr_ready)
      else $error("unsupported wide form was not refused");

   wait_stall_a: assert property (state == ICT_ST_EXEC && bus_wait
      |=> !retire && !instr_ready)
      else $error("retired during a bus wait");

   sleep_hint_a: assert property ((take_nw && instr_hw1 == 16'hbf30) ##1 !bus_wait
      |=> sleeping && !retire && !instr_ready && cycles_used == 8'h02)
      else $error("sleep hint did not count two cycles");

endmodule : ict_timing

// *** verification/ict_bus_model.sv ***
// bus and i/o port stand-in that stretches an access by a requested number of wait cycles
`timescale 1ns/1ps
module ict_bus_model (
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       start,
   input  wire logic [3:0] wait_n,
   output logic            bus_wait
);
   logic [3:0] left;
   // ==========================================================================
   // wait counter: zero answers promptly, anything else answers slowly
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         left <= 4'h0;
      end else if (start) begin
         left <= wait_n;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end
   assign bus_wait = (left != 4'h0);
endmodule : ict_bus_model

// *** verification/instruction_cycle_timing_tb.sv ***
// self-checking bench for the instruction cycle timing sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
         mismatches++; \
      end \
   end
module instruction_cycle_timing_tb;
   import ict_pkg::*;
   // cyc of zero marks an encoding that must fault
   typedef struct packed {
      logic [15:0] h1;
      logic [15:0] h2;
      logic        c;
      logic        io;
      logic [7:0]  cyc;
   } ict_row_t;
   logic        clk_sys     = 1'b0;
   logic        reset_n     = 1'b0;
   logic        instr_valid = 1'b0;
   logic [15:0] instr_hw1   = 16'h0000;
   logic [15:0] instr_hw2   = 16'h0000;
   logic        cond_pass   = 1'b0;
   logic        target_io   = 1'b0;
   logic        wake_event  = 1'b0;
   logic        start       = 1'b0;
   logic [3:0]  wait_n      = 4'h0;
   logic        bus_wait;
   logic        instr_ready;
   logic        retire;
   logic        undef_fault;
   logic        sleeping;
   logic [7:0]  cycles_used;
   int          mismatches  = 0;
   int          n_tests     = 0;
   int          n;
   ict_row_t    rows [36] = '{
      '{16'h4340, 16'h0000, 1'b0, 1'b0, 8'h01}, '{16'h1888, 16'h0000, 1'b0, 1'b0, 8'h01},
      '{16'h1c48, 16'h0000, 1'b0, 1'b0, 8'h01}, '{16'h46f7, 16'h0000, 1'b0, 1'b0, 8'h02},
      '{16'h44ff, 16'h0000, 1'b0, 1'b0, 8'h02}, '{16'h0088, 16'h0000, 1'b0, 1'b0, 8'h01},
      '{16'h4088, 16'h0000, 1'b0, 1'b0, 8'h01}, '{16'h41c8, 16'h0000, 1'b0, 1'b0, 8'h01},
      '{16'h6800, 16'h0000, 1'b0, 1'b0, 8'h02}, '{16'h6800, 16'h0000, 1'b0, 1'b1, 8'h01},
      '{16'h5e08, 16'h0000, 1'b0, 1'b0, 8'h02}, '{16'h4801, 16'h0000, 1'b0, 1'b0, 8'h02},
      '{16'h9001, 16'h0000, 1'b0, 1'b1, 8'h01}, '{16'hb501, 16'h0000, 1'b0, 1'b0, 8'h03},
      '{16'hbd01, 16'h0000, 1'b0, 1'b0, 8'h05}, '{16'hc8ff, 16'h0000, 1'b0, 1'b0, 8'h09},
      '{16'hd000, 16'h0000, 1'b1, 1'b0, 8'h02}, '{16'hd000, 16'h0000, 1'b0, 1'b0, 8'h01},
      '{16'he000, 16'h0000, 1'b0, 1'b0, 8'h02}, '{16'hf000, 16'hf800, 1'b0, 1'b0, 8'h03},
      '{16'h4788, 16'h0000, 1'b0, 1'b0, 8'h02}, '{16'hb200, 16'h0000, 1'b0, 1'b0, 8'h01},
      '{16'hba00, 16'h0000, 1'b0, 1'b0, 8'h01}, '{16'hbac0, 16'h0000, 1'b0, 1'b0, 8'h01},
      '{16'hf3bf, 16'h8f5f, 1'b0, 1'b0, 8'h03}, '{16'hf3bf, 16'h8f6f, 1'b0, 1'b0, 8'h03},
      '{16'hf3ef, 16'h8000, 1'b0, 1'b0, 8'h03}, '{16'hf380, 16'h8800, 1'b0, 1'b0, 8'h03},
      '{16'hb672, 16'h0000, 1'b0, 1'b0, 8'h01}, '{16'hbf40, 16'h0000, 1'b0, 1'b0, 8'h01},
      '{16'hb662, 16'h0000, 1'b0, 1'b0, 8'h01}, '{16'hbf10, 16'h0000, 1'b0, 1'b0, 8'h01},
      '{16'hb100, 16'h0000, 1'b0, 1'b0, 8'h00}, '{16'hbf08, 16'h0000, 1'b0, 1'b0, 8'h00},
      '{16'he800, 16'h0000, 1'b0, 1'b0, 8'h00}, '{16'hba80, 16'h0000, 1'b0, 1'b0, 8'h00}};

   ict_timing u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .instr_valid(instr_valid),
      .instr_hw1(instr_hw1), .instr_hw2(instr_hw2), .cond_pass(cond_pass),
      .target_io(target_io), .bus_wait(bus_wait), .wake_event(wake_event),
      .instr_ready(instr_ready), .retire(retire), .undef_fault(undef_fault),
      .sleeping(sleeping), .cycles_used(cycles_used));
   ict_bus_model u_bus (.clk_sys(clk_sys), .reset_n(reset_n), .start(start),
      .wait_n(wait_n), .bus_wait(bus_wait));

   always #25 clk_sys = ~clk_sys;

   // ==========================================================================
   // verdict; also reached when a wait runs out
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   // counts cycles from the take edge until a finish (sel 0) or suspension (sel 1);
   // called in the take time step, so a one-cycle pulse is seen right after that edge
   task automatic count_until(input bit sel);
      n = 1;
      #1;
      while (((sel ? sleeping : (retire | undef_fault)) !== 1'b1) && n < 40) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (n >= 40) begin
         $display("[FAIL] wait ran out expected finish seen none");
         mismatches++;
         summarize();
      end
   endtask : count_until

   // offer one instruction, hold it through the take edge, then time it
   task automatic run_op(input ict_row_t r, input logic [3:0] w);
      `CHK("ready_before", 1'b1, instr_ready)
      @(posedge clk_sys);
      instr_valid <= 1'b1;
      instr_hw1   <= r.h1;
      instr_hw2   <= r.h2;
      cond_pass   <= r.c;
      target_io   <= r.io;
      start       <= (w != 4'h0);
      wait_n      <= w;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      start       <= 1'b0;
      count_until(1'b0);
      `CHK("fault", (r.cyc == 8'h00), undef_fault)
      `CHK("cycles", ((r.cyc == 8'h00) ? 8'h01 : (r.cyc + {4'h0, w})), n[7:0])
      if (r.cyc != 8'h00) `CHK("cycles_used", (r.cyc + {4'h0, w}), cycles_used)
   endtask : run_op

   task automatic check_idle();
      `CHK("reset_vals", 12'h800, ({instr_ready, retire, undef_fault, sleeping, cycles_used}))
   endtask : check_idle

   // ==========================================================================
   // main sequence: table rows, then waits, sleep, back to back, reset
   initial begin
      repeat (8) @(posedge clk_sys);
      #1 check_idle();
      reset_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      foreach (rows[i]) run_op(rows[i], 4'h0);
      run_op('{16'h6800, 16'h0000, 1'b0, 1'b0, 8'h02}, 4'h2);
      run_op('{16'hb501, 16'h0000, 1'b0, 1'b0, 8'h03}, 4'h1);
      // both sleep hints: 2 cycles to suspend, time asleep not counted
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys);
         instr_valid <= 1'b1;
         instr_hw1   <= (k == 0) ? 16'hbf30 : 16'hbf20;
         @(posedge clk_sys);
         instr_valid <= 1'b0;
         count_until(1'b1);
         `CHK("sleep_cycles", 8'h02, n[7:0])
         `CHK("sleep_used", 8'h02, cycles_used)
         repeat (4) @(posedge clk_sys);
         #1 `CHK("asleep", 3'b100, ({sleeping, retire, instr_ready}))
         @(posedge clk_sys);
         wake_event <= 1'b1;
         @(posedge clk_sys);
         wake_event <= 1'b0;
         #1 `CHK("woken", 5'b01110, ({sleeping, retire, instr_ready, cycles_used[1:0]}))
      end
      // back to back single-cycle ops with valid held high
      @(posedge clk_sys);
      instr_valid <= 1'b1;
      instr_hw1   <= 16'h4340;
      @(posedge clk_sys);
      instr_hw1   <= 16'hba40;
      // each retire pulse stands for one cycle only, so look right after its edge
      #1 `CHK("b2b_first", 2'b11, ({retire, instr_ready}))
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      #1 `CHK("b2b_second", 2'b11, ({retire, instr_ready}))
      // reset in the middle of a long pop
      @(posedge clk_sys);
      instr_valid <= 1'b1;
      instr_hw1   <= 16'hbd01;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b0;
      @(posedge clk_sys);
      #1 check_idle();
      reset_n <= 1'b1;
      @(posedge clk_sys);
      #1 run_op('{16'hc107, 16'h0000, 1'b0, 1'b0, 8'h04}, 4'h0);
      summarize();
   end
endmodule : instruction_cycle_timing_tb
